// file: design/alfr_pkg.sv
package alfr_pkg;
  // ---------------------------------------------------------------
  // opcodes
  // ---------------------------------------------------------------
  localparam logic [9:0] OPC_LOAD_ACC_FROM_ADC_CTRL = 10'h244;
  localparam logic [9:0] OPC_LOAD_ACC_FROM_STACK_PTR = 10'h050;
  localparam logic [9:0] OPC_LOAD_ACC_FROM_IRQ_CTRL_FIRST = 10'h054;
  localparam logic [9:0] OPC_LOAD_ACC_FROM_IRQ_CTRL_SECOND = 10'h055;
  localparam logic [9:0] OPC_LOAD_ACC_FROM_TIMER_CTRL_FIRST = 10'h24b;
  // ---------------------------------------------------------------
  // widths and reset values
  // ---------------------------------------------------------------
  localparam int ALFR_ACC_W = 4;
  localparam int ALFR_SP_W = 3;
  localparam logic [3:0] ALFR_ACC_RESET = 4'h0;
  localparam logic ALFR_CARRY_RESET = 1'b0;

  typedef enum logic [2:0] {
    ALFR_SRC_NONE = 3'b000,
    ALFR_SRC_ADC = 3'b001,
    ALFR_SRC_SP = 3'b010,
    ALFR_SRC_V1 = 3'b011,
    ALFR_SRC_V2 = 3'b100,
    ALFR_SRC_W1 = 3'b101
  } alfr_src_t;
endpackage : alfr_pkg

// file: design/alfr_decode.sv
`timescale 1ns/100ps
module alfr_decode
  import alfr_pkg::*;
(
  input wire logic [9:0] opcode_in,
  input wire logic valid_in,
  output alfr_src_t src_out
);
  // ---------------------------------------------------------------
  // opcode to source select
  // ---------------------------------------------------------------
  function automatic alfr_src_t alfr_decode_op(input logic [9:0] op);
    case (op)
      OPC_LOAD_ACC_FROM_ADC_CTRL: alfr_decode_op = ALFR_SRC_ADC;
      OPC_LOAD_ACC_FROM_STACK_PTR: alfr_decode_op = ALFR_SRC_SP;
      OPC_LOAD_ACC_FROM_IRQ_CTRL_FIRST: alfr_decode_op = ALFR_SRC_V1;
      OPC_LOAD_ACC_FROM_IRQ_CTRL_SECOND: alfr_decode_op = ALFR_SRC_V2;
      OPC_LOAD_ACC_FROM_TIMER_CTRL_FIRST: alfr_decode_op = ALFR_SRC_W1;
      default: alfr_decode_op = ALFR_SRC_NONE;
    endcase
  endfunction : alfr_decode_op

  assign src_out = valid_in ? alfr_decode_op(opcode_in) : ALFR_SRC_NONE;
endmodule : alfr_decode

// file: design/alfr_core.sv
`timescale 1ns/100ps
module alfr_core
  import alfr_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rstn_in,
  input wire logic [9:0] opcode_in,
  input wire logic opcode_valid_in,
  input wire logic [3:0] adc_control_reg_in,
  input wire logic [2:0] stack_pointer_in,
  input wire logic [3:0] irq_control_first_in,
  input wire logic [3:0] irq_control_second_in,
  input wire logic [3:0] timer_control_first_in,
  input wire logic carry_we_in,
  input wire logic carry_d_in,
  input wire logic acc_we_in,
  input wire logic [3:0] acc_d_in,
  output logic [3:0] acc_out,
  output logic carry_flag_out,
  output logic skip_out,
  output logic transfer_done_out
);
  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  alfr_src_t src;
  logic [3:0] acc_reg;
  logic [3:0] acc_next;
  logic carry_reg;
  logic done_reg;

  alfr_decode u_decode (
    .opcode_in(opcode_in),
    .valid_in(opcode_valid_in),
    .src_out(src)
  );

  // ---------------------------------------------------------------
  // accumulator source mux
  // ---------------------------------------------------------------
  always_comb begin
    acc_next = acc_reg;
    case (src)
      ALFR_SRC_ADC: acc_next = adc_control_reg_in;
      ALFR_SRC_SP: acc_next = {1'b0, stack_pointer_in};
      ALFR_SRC_V1: acc_next = irq_control_first_in;
      ALFR_SRC_V2: acc_next = irq_control_second_in;
      ALFR_SRC_W1: acc_next = timer_control_first_in;
      // other instructions own the accumulator through the core port
      ALFR_SRC_NONE: begin
        if (acc_we_in) begin
          acc_next = acc_d_in;
        end
      end
      default: acc_next = acc_reg;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      acc_reg <= ALFR_ACC_RESET;
    end else begin
      acc_reg <= acc_next;
    end
  end

  // ---------------------------------------------------------------
  // carry: writes from elsewhere blocked during a transfer
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      carry_reg <= ALFR_CARRY_RESET;
    end else if (carry_we_in && (src == ALFR_SRC_NONE)) begin
      carry_reg <= carry_d_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= (src != ALFR_SRC_NONE);
    end
  end

  assign acc_out = acc_reg;
  assign carry_flag_out = carry_reg;
  // transfers never skip; no skip source lives here
  assign skip_out = 1'b0;
  assign transfer_done_out = done_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_adc_load: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    opcode_valid_in && opcode_in == OPC_LOAD_ACC_FROM_ADC_CTRL |=>
      acc_out == $past(adc_control_reg_in) && transfer_done_out)
    else $error("adc control load wrong");

  a_sp_load: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    opcode_valid_in && opcode_in == OPC_LOAD_ACC_FROM_STACK_PTR |=>
      acc_out == {1'b0, $past(stack_pointer_in)} && !acc_out[3])
    else $error("stack pointer load wrong");

  a_v1_load: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    opcode_valid_in && opcode_in == OPC_LOAD_ACC_FROM_IRQ_CTRL_FIRST |=>
      acc_out == $past(irq_control_first_in))
    else $error("irq control first load wrong");

  a_v2_load: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    opcode_valid_in && opcode_in == OPC_LOAD_ACC_FROM_IRQ_CTRL_SECOND |=>
      acc_out == $past(irq_control_second_in))
    else $error("irq control second load wrong");

  a_w1_load: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    opcode_valid_in && opcode_in == OPC_LOAD_ACC_FROM_TIMER_CTRL_FIRST |=>
      acc_out == $past(timer_control_first_in))
    else $error("timer control first load wrong");

  a_carry_kept: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    src != ALFR_SRC_NONE |=> $stable(carry_flag_out))
    else $error("carry changed during transfer");

  a_no_skip: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    transfer_done_out |-> !skip_out)
    else $error("skip raised by transfer");

  a_idle_hold: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    src == ALFR_SRC_NONE && !acc_we_in |=> $stable(acc_out) && !transfer_done_out)
    else $error("accumulator changed without cause");

  // ---------------------------------------------------------------
  // reference decode for the checks
  // ---------------------------------------------------------------
  // kept apart from the decoder, so a wrong decoder entry is not
  // mirrored into the checks that should catch it
  function automatic logic alfr_is_xfer(input logic [9:0] op);
    case (op)
      OPC_LOAD_ACC_FROM_ADC_CTRL,
      OPC_LOAD_ACC_FROM_STACK_PTR,
      OPC_LOAD_ACC_FROM_IRQ_CTRL_FIRST,
      OPC_LOAD_ACC_FROM_IRQ_CTRL_SECOND,
      OPC_LOAD_ACC_FROM_TIMER_CTRL_FIRST: alfr_is_xfer = 1'b1;
      default: alfr_is_xfer = 1'b0;
    endcase
  endfunction : alfr_is_xfer

  a_done_pulse: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    opcode_valid_in && alfr_is_xfer(opcode_in) |=> transfer_done_out)
    else $error("transfer done pulse missing");

  a_done_quiet: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    !(opcode_valid_in && alfr_is_xfer(opcode_in)) |=> !transfer_done_out)
    else $error("transfer done without transfer");

  a_carry_blocked: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    opcode_valid_in && alfr_is_xfer(opcode_in) |=> carry_flag_out == $past(carry_flag_out))
    else $error("carry written during transfer");

  a_carry_write: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    !(opcode_valid_in && alfr_is_xfer(opcode_in)) && carry_we_in |=>
      carry_flag_out == $past(carry_d_in))
    else $error("carry write from core lost");

  a_acc_write: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    !(opcode_valid_in && alfr_is_xfer(opcode_in)) && acc_we_in |=>
      acc_out == $past(acc_d_in))
    else $error("accumulator write from core lost");

  a_valid_gate: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    !opcode_valid_in && !acc_we_in |=> $stable(acc_out))
    else $error("accumulator moved without valid opcode");

  a_skip_never: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    opcode_valid_in |=> !skip_out)
    else $error("skip raised");

  // no disable here: the values while reset is held are checked too
  a_reset_state: assert property (@(posedge sys_clk_in)
    !rstn_in |-> acc_out == ALFR_ACC_RESET && carry_flag_out == ALFR_CARRY_RESET && !transfer_done_out)
    else $error("state wrong during reset");

  // ---------------------------------------------------------------
  // per-bit transfer checks
  // ---------------------------------------------------------------
  // bit-level checks name the lane that broke, which whole-word
  // compares above do not
  genvar gi;
  generate
    for (gi = 0; gi < ALFR_ACC_W; gi++) begin : g_acc_bit_chk
      a_bit_adc: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        opcode_valid_in && opcode_in == OPC_LOAD_ACC_FROM_ADC_CTRL |=>
          acc_out[gi] == $past(adc_control_reg_in[gi]))
        else $error("adc control bit lost");

      a_bit_v1: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        opcode_valid_in && opcode_in == OPC_LOAD_ACC_FROM_IRQ_CTRL_FIRST |=>
          acc_out[gi] == $past(irq_control_first_in[gi]))
        else $error("irq control first bit lost");

      a_bit_v2: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        opcode_valid_in && opcode_in == OPC_LOAD_ACC_FROM_IRQ_CTRL_SECOND |=>
          acc_out[gi] == $past(irq_control_second_in[gi]))
        else $error("irq control second bit lost");

      a_bit_w1: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        opcode_valid_in && opcode_in == OPC_LOAD_ACC_FROM_TIMER_CTRL_FIRST |=>
          acc_out[gi] == $past(timer_control_first_in[gi]))
        else $error("timer control bit lost");
    end
  endgenerate

  genvar si;
  generate
    for (si = 0; si < ALFR_SP_W; si++) begin : g_sp_bit_chk
      a_bit_sp: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
        opcode_valid_in && opcode_in == OPC_LOAD_ACC_FROM_STACK_PTR |=>
          acc_out[si] == $past(stack_pointer_in[si]))
        else $error("stack pointer bit lost");
    end
  endgenerate
endmodule : alfr_core

// file: testbench/accumulator_load_from_regs_test.sv
`timescale 1ns/100ps
module accumulator_load_from_regs_test
  import alfr_pkg::*;
;
  // ------------------------------------------------
  // stimulus and design
  // ------------------------------------------------
  logic sys_clk_in = 1'b0, rstn_in = 1'b1, opcode_valid_in = 1'b0;
  logic carry_we_in = 1'b0, carry_d_in = 1'b0, acc_we_in = 1'b0;
  logic [9:0] opcode_in = 10'h000;
  logic [3:0] adc_control_reg_in = 4'ha, irq_control_first_in = 4'hc;
  logic [3:0] irq_control_second_in = 4'h3, timer_control_first_in = 4'he, acc_d_in = 4'h0;
  logic [2:0] stack_pointer_in = 3'h7;
  logic [3:0] acc_out;
  logic carry_flag_out, skip_out, transfer_done_out;
  int miscompares = 0, checked = 0;

  always #5 sys_clk_in = ~sys_clk_in;

  alfr_core dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .opcode_in(opcode_in),
    .opcode_valid_in(opcode_valid_in), .adc_control_reg_in(adc_control_reg_in),
    .stack_pointer_in(stack_pointer_in), .irq_control_first_in(irq_control_first_in),
    .irq_control_second_in(irq_control_second_in), .timer_control_first_in(timer_control_first_in),
    .carry_we_in(carry_we_in), .carry_d_in(carry_d_in), .acc_we_in(acc_we_in), .acc_d_in(acc_d_in),
    .acc_out(acc_out), .carry_flag_out(carry_flag_out), .skip_out(skip_out),
    .transfer_done_out(transfer_done_out));

  // ------------------------------------------------
  // compares and verdict
  // ------------------------------------------------
  task chk4(input logic [3:0] got, input logic [3:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t acc got %h want %h", $time, got, exp);
    end
  endtask : chk4

  task chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t flag got %b want %b", $time, got, exp);
    end
  endtask : chk1

  task give_verdict;
    if (miscompares == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  // ------------------------------------------------
  // one instruction: carry set first, then the opcode with
  // competing acc and carry writes that a transfer must beat
  // ------------------------------------------------
  task exec(input logic [9:0] op, input logic [3:0] exp_acc, input logic is_xfer);
    @(posedge sys_clk_in);
    carry_we_in <= 1'b1;
    carry_d_in <= 1'b1;
    @(posedge sys_clk_in);
    opcode_in <= op;
    opcode_valid_in <= 1'b1;
    acc_we_in <= 1'b1;
    acc_d_in <= 4'h9;
    carry_d_in <= 1'b0;
    @(posedge sys_clk_in);
    opcode_valid_in <= 1'b0;
    acc_we_in <= 1'b0;
    carry_we_in <= 1'b0;
    #1;
    chk4(acc_out, exp_acc);
    chk1(transfer_done_out, is_xfer);
    chk1(carry_flag_out, is_xfer);
    chk1(skip_out, 1'b0);
    @(posedge sys_clk_in);
    #1;
    chk1(transfer_done_out, 1'b0);
  endtask : exec

  // ------------------------------------------------
  // main sequence
  // ------------------------------------------------
  initial begin
    // a real falling edge, so the asynchronous reset branch runs
    rstn_in <= 1'b0;
    repeat (12) @(posedge sys_clk_in);
    chk4(acc_out, ALFR_ACC_RESET);
    chk1(carry_flag_out, ALFR_CARRY_RESET);
    rstn_in <= 1'b1;
    exec(OPC_LOAD_ACC_FROM_ADC_CTRL, 4'ha, 1'b1);
    exec(OPC_LOAD_ACC_FROM_STACK_PTR, 4'h7, 1'b1);
    exec(OPC_LOAD_ACC_FROM_IRQ_CTRL_FIRST, 4'hc, 1'b1);
    exec(OPC_LOAD_ACC_FROM_IRQ_CTRL_SECOND, 4'h3, 1'b1);
    exec(OPC_LOAD_ACC_FROM_TIMER_CTRL_FIRST, 4'he, 1'b1);
    // near-miss opcode: plain writes must land, no done pulse
    exec(10'h245, 4'h9, 1'b0);
    give_verdict();
  end

  initial begin
    #100000;
    miscompares++;
    give_verdict();
  end
endmodule : accumulator_load_from_regs_test
